/* File: logic/ofr_output_fault_retry.sv */
// Purpose: over-current response and restart sequencing of the output
// Assumes: measured current arrives on clk in linear format; floor flag
//   and on/off level come from pins
// Notes: the analog loop does the clamping; this block says when and stops
`timescale 1ns/1ps
`default_nettype none

module ofr_output_fault_retry #(
	parameter int UNIT_W = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic [UNIT_W-1:0] delay_unit_cycles,
	input wire logic [15:0] iout_meas,
	input wire logic vout_low_pin,
	input wire logic on_pin,
	input wire logic other_fault,
	input wire logic clear_faults,
	output logic out_enable,
	output logic [15:0] oc_limit,
	output logic host_notify,
	output ofr_pkg::ofr_status_t status
);

	if (UNIT_W < 1 || UNIT_W > 32) begin : g_unit_w_bad
		$error("UNIT_W out of range");
	end

	// ====================================================================
	// linear to fixed point, fraction of OFR_LIN_FRAC_BITS bits
	function automatic logic signed [47:0] lin_val(input logic [15:0] w);
		logic signed [47:0] m;
		logic [5:0] sh;
		m = {{37{w[10]}}, w[10:0]};
		m = m <<< ofr_pkg::OFR_LIN_FRAC_BITS;
		sh = 6'h20 - {1'b0, w[15:ofr_pkg::OFR_LIN_EXP_LSB]};
		if (w[15]) begin
			lin_val = m >>> sh;
		end else begin
			lin_val = m <<< w[15:ofr_pkg::OFR_LIN_EXP_LSB];
		end
	endfunction

	// ====================================================================
	// pin synchronisers
	logic vlow_meta_reg, vlow_reg, on_meta_reg, on_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			vlow_meta_reg <= 1'b0;
			vlow_reg <= 1'b0;
			on_meta_reg <= 1'b0;
			on_reg <= 1'b0;
		end else if (ce) begin
			vlow_meta_reg <= vout_low_pin;
			vlow_reg <= vlow_meta_reg;
			on_meta_reg <= on_pin;
			on_reg <= on_meta_reg;
		end
	end

	// ====================================================================
	// registers
	logic [15:0] thresh_reg;
	ofr_pkg::ofr_resp_t resp_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			thresh_reg <= ofr_pkg::OFR_RST_OC_THRESHOLD;
			resp_reg <= ofr_pkg::OFR_RST_OC_RESPONSE;
		end else if (ce && reg_wr) begin
			if (reg_addr == ofr_pkg::OFR_ADDR_OC_THRESHOLD) begin
				thresh_reg <= reg_wdata;
			end else if (reg_addr == ofr_pkg::OFR_ADDR_OC_RESPONSE) begin
				resp_reg <= reg_wdata[7:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (ce && reg_rd) begin
			if (reg_addr == ofr_pkg::OFR_ADDR_OC_THRESHOLD) begin
				reg_rdata <= thresh_reg;
			end else if (reg_addr == ofr_pkg::OFR_ADDR_OC_RESPONSE) begin
				reg_rdata <= {8'h00, resp_reg};
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	assign oc_limit = thresh_reg;

	// ====================================================================
	// fault detect and sequencing
	logic oc_now;
	assign oc_now = lin_val(iout_meas) > lin_val(thresh_reg);

	ofr_pkg::ofr_state_t state_reg;
	logic [2:0] attempts_reg;
	logic tmr_done_reg;
	logic tmr_start;
	logic shut_req;
	logic latch_now;

	// mode 3 is handled like delayed limiting
	always_comb begin
		shut_req = 1'b0;
		if (state_reg == ofr_pkg::OFR_LIMIT && oc_now) begin
			if (resp_reg.mode == ofr_pkg::OFR_MODE_CONDITIONED) begin
				shut_req = vlow_reg;
			end else if (resp_reg.mode != ofr_pkg::OFR_MODE_BRICKWALL) begin
				shut_req = tmr_done_reg;
			end
		end
	end

	// out of attempts latches; endless retry never does
	assign latch_now = resp_reg.retries == ofr_pkg::OFR_RETRY_NONE
		|| (resp_reg.retries != ofr_pkg::OFR_RETRY_ENDLESS
		&& attempts_reg >= resp_reg.retries);
	logic run_ok;
	assign run_ok = on_reg && !other_fault;

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= ofr_pkg::OFR_OFF;
		end else if (ce) begin
			if (state_reg != ofr_pkg::OFR_LATCH && !run_ok) begin
				state_reg <= ofr_pkg::OFR_OFF;
			end else begin
				case (state_reg)
				ofr_pkg::OFR_OFF: begin
					state_reg <= ofr_pkg::OFR_RUN;
				end
				ofr_pkg::OFR_RUN: begin
					if (oc_now) begin
						state_reg <= ofr_pkg::OFR_LIMIT;
					end
				end
				ofr_pkg::OFR_LIMIT: begin
					if (shut_req) begin
						state_reg <= latch_now ? ofr_pkg::OFR_LATCH
							: ofr_pkg::OFR_WAIT;
					end else if (!oc_now) begin
						state_reg <= ofr_pkg::OFR_RUN;
					end
				end
				ofr_pkg::OFR_WAIT: begin
					if (tmr_done_reg) begin
						state_reg <= ofr_pkg::OFR_RUN;
					end
				end
				ofr_pkg::OFR_LATCH: begin
					if (clear_faults) begin
						state_reg <= ofr_pkg::OFR_OFF;
					end
				end
				default: begin
					state_reg <= ofr_pkg::OFR_OFF;
				end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			attempts_reg <= 3'h0;
		end else if (ce) begin
			if (state_reg == ofr_pkg::OFR_OFF) begin
				attempts_reg <= 3'h0;
			end else if (state_reg == ofr_pkg::OFR_WAIT && tmr_done_reg
				&& run_ok) begin
				if (attempts_reg != 3'h7) begin
					attempts_reg <= attempts_reg + 3'h1;
				end
			end else if (state_reg == ofr_pkg::OFR_RUN && !oc_now
				&& tmr_done_reg && attempts_reg != 3'h0) begin
				attempts_reg <= 3'h0;
			end
		end
	end

	// ====================================================================
	// delay timer: 2**rtime units of delay_unit_cycles each
	assign tmr_start = run_ok && ((state_reg == ofr_pkg::OFR_RUN && oc_now)
		|| shut_req || (state_reg == ofr_pkg::OFR_WAIT && tmr_done_reg));

	logic [UNIT_W-1:0] unit_cnt_reg;
	logic [7:0] units_cnt_reg;
	logic [7:0] units_target;
	assign units_target = 8'(8'h01 << resp_reg.rtime);

	always_ff @(posedge clk) begin
		if (reset) begin
			unit_cnt_reg <= '0;
			units_cnt_reg <= 8'h00;
			tmr_done_reg <= 1'b0;
		end else if (ce) begin
			if (tmr_start) begin
				unit_cnt_reg <= '0;
				units_cnt_reg <= 8'h00;
				tmr_done_reg <= 1'b0;
			end else if (!tmr_done_reg) begin
				// a zero unit setting counts as one cycle, never stalls
				if (unit_cnt_reg + UNIT_W'(1) >= delay_unit_cycles) begin
					unit_cnt_reg <= '0;
					units_cnt_reg <= units_cnt_reg + 8'h01;
					if (units_cnt_reg + 8'h01 == units_target) begin
						tmr_done_reg <= 1'b1;
					end
				end else begin
					unit_cnt_reg <= unit_cnt_reg + UNIT_W'(1);
				end
			end
		end
	end

	// ====================================================================
	// status, set wins over clear
	logic oc_flag_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			oc_flag_reg <= 1'b0;
		end else if (ce) begin
			if (oc_now && (state_reg == ofr_pkg::OFR_RUN
				|| state_reg == ofr_pkg::OFR_LIMIT)) begin
				oc_flag_reg <= 1'b1;
			end else if (clear_faults) begin
				oc_flag_reg <= 1'b0;
			end
		end
	end

	assign host_notify = oc_flag_reg;
	assign out_enable = state_reg == ofr_pkg::OFR_RUN
		|| state_reg == ofr_pkg::OFR_LIMIT;
	assign status = '{oc_fault: oc_flag_reg,
		limiting: state_reg == ofr_pkg::OFR_LIMIT,
		latched: state_reg == ofr_pkg::OFR_LATCH,
		attempts: attempts_reg};

	// ====================================================================
	// checks
	a_latch_holds: assert property (@(posedge clk) disable iff (reset)
		state_reg == ofr_pkg::OFR_LATCH && !clear_faults
		|=> !out_enable)
		else $error("output came back on while latched");
	a_no_retry_latch: assert property (@(posedge clk) disable iff (reset)
		ce && run_ok && shut_req
		&& resp_reg.retries == ofr_pkg::OFR_RETRY_NONE
		|=> state_reg == ofr_pkg::OFR_LATCH)
		else $error("zero retries did not latch off");
	a_endless_never: assert property (@(posedge clk) disable iff (reset)
		ce && resp_reg.retries == ofr_pkg::OFR_RETRY_ENDLESS
		&& state_reg != ofr_pkg::OFR_LATCH
		|=> state_reg != ofr_pkg::OFR_LATCH)
		else $error("endless retry latched off");
	a_attempt_cap: assert property (@(posedge clk) disable iff (reset)
		resp_reg.retries != ofr_pkg::OFR_RETRY_ENDLESS
		&& $stable(resp_reg) && $past(ce) && !$past(reset)
		&& $past(attempts_reg) <= resp_reg.retries
		|-> attempts_reg <= resp_reg.retries)
		else $error("more restarts than programmed");
	a_status_set: assert property (@(posedge clk) disable iff (reset)
		ce && oc_now && state_reg == ofr_pkg::OFR_RUN
		|=> host_notify && status.oc_fault)
		else $error("over-current not flagged");
	a_brickwall_stays: assert property (@(posedge clk) disable iff (reset)
		ce && run_ok && state_reg == ofr_pkg::OFR_LIMIT
		&& resp_reg.mode == ofr_pkg::OFR_MODE_BRICKWALL
		|=> out_enable)
		else $error("brickwall mode shut the output down");
	a_floor_shut: assert property (@(posedge clk) disable iff (reset)
		ce && state_reg == ofr_pkg::OFR_LIMIT && oc_now && vlow_reg
		&& resp_reg.mode == ofr_pkg::OFR_MODE_CONDITIONED
		|=> !out_enable)
		else $error("below floor but output still on");
	a_delay_hold: assert property (@(posedge clk) disable iff (reset)
		ce && run_ok && state_reg == ofr_pkg::OFR_LIMIT && !tmr_done_reg
		&& resp_reg.mode == ofr_pkg::OFR_MODE_DELAYED
		|=> out_enable)
		else $error("delayed limiting ended early");
	a_wait_off: assert property (@(posedge clk) disable iff (reset)
		ce && state_reg == ofr_pkg::OFR_WAIT && !tmr_done_reg
		|=> !out_enable)
		else $error("restart before delay elapsed");

endmodule

`default_nettype wire

/* File: shared/ofr_pkg.sv */
// Purpose: shared constants and types of the output fault retry control
// Assumes: command codes are decoded upstream of the register port
// Notes: the low-voltage floor comparison arrives as a pin-level flag
//
// What this block does
// - retry field one to six: that many restarts, then latch output off
// - retry field all ones: restart forever until commanded off or faulted
// - restart starts spaced by retry-time delay times the fault's unit
// - retry-time n selects 2**n units, for run-on delay and spacing
// - delay unit size comes from a separate unit setting
// - hold 16-bit linear over-current threshold compared to output current
// - every response code sets the over-current status bit and notifies
// - code zero: brickwall limiting at threshold forever
// - code one: limit forever while output voltage stays above floor
// - code one: voltage below floor shuts down then follows retry count
// - code two: limit regardless of voltage for the retry-time delay
// - still limiting when that delay ends: follow retry count
// - retry field zero: no restart, output off until fault cleared
package ofr_pkg;

	// ====================================================================
	// register map
	localparam logic [7:0] OFR_ADDR_OC_THRESHOLD = 8'h46;
	localparam logic [7:0] OFR_ADDR_OC_RESPONSE = 8'h47;
	localparam logic [15:0] OFR_RST_OC_THRESHOLD = 16'h0000;
	localparam logic [7:0] OFR_RST_OC_RESPONSE = 8'h00;

	// ====================================================================
	// response field layout
	localparam int OFR_MODE_MSB = 7;
	localparam int OFR_MODE_LSB = 6;
	localparam int OFR_RETRY_MSB = 5;
	localparam int OFR_RETRY_LSB = 3;
	localparam int OFR_RTIME_MSB = 2;
	localparam int OFR_RTIME_LSB = 0;

	localparam logic [1:0] OFR_MODE_BRICKWALL = 2'h0;
	localparam logic [1:0] OFR_MODE_CONDITIONED = 2'h1;
	localparam logic [1:0] OFR_MODE_DELAYED = 2'h2;
	localparam logic [2:0] OFR_RETRY_NONE = 3'h0;
	localparam logic [2:0] OFR_RETRY_ENDLESS = 3'h7;

	// linear format: 5-bit signed exponent above 11-bit signed mantissa
	localparam int OFR_LIN_EXP_LSB = 11;
	localparam int OFR_LIN_FRAC_BITS = 16;

	// ====================================================================
	// types
	typedef enum logic [2:0] {
		OFR_OFF,
		OFR_RUN,
		OFR_LIMIT,
		OFR_WAIT,
		OFR_LATCH
	} ofr_state_t;

	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] retries;
		logic [2:0] rtime;
	} ofr_resp_t;

	typedef struct packed {
		logic oc_fault;
		logic limiting;
		logic latched;
		logic [2:0] attempts;
	} ofr_status_t;

endpackage

/* File: testbench/ofr_host_model.sv */
// Purpose: host side of the register port, one transfer per wr or rd call, two per setup call
// Assumes: strobes taken at the rising edge, read data one edge later
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module ofr_host_model (
	input wire logic clk,
	output var logic reg_wr,
	output var logic reg_rd,
	output var logic [7:0] reg_addr,
	output var logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'hff;
		reg_wdata = 16'hffff;
	end
	// ====================================================================
	// transfers
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
	// limit and response land while the output is still off
	task automatic setup(input logic [15:0] lim, input logic [7:0] resp);
		wr(8'h46, lim);
		wr(8'h47, {8'h00, resp});
	endtask
endmodule
`default_nettype wire

/* File: testbench/output_fault_retry_control_tb.sv */
// Purpose: scenario bench of the over-current response and retries
// Assumes: one delay unit is two clocks, three in the delayed-limit case;
//   threshold 16 A, exponent zero
// Notes: restart spacing is judged within a small slack of the delay
`timescale 1ns/1ps
`default_nettype none
module output_fault_retry_control_tb;
	localparam int UNIT = 2;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic on_pin = 1'b0;
	logic vout_low_pin = 1'b0;
	logic other_fault = 1'b0;
	logic clear_faults = 1'b0;
	logic [15:0] iout_meas = 16'h0004;
	logic ce = 1'b1;
	logic [15:0] unit_cycles = 16'(UNIT);
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic [15:0] oc_limit;
	logic out_enable;
	logic host_notify;
	ofr_pkg::ofr_status_t status;
	int n_mismatch = 0;
	int n_tests = 0;
	always #12.5 clk = ~clk;
	ofr_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	ofr_output_fault_retry dut (.clk(clk), .reset(reset), .ce(ce),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.delay_unit_cycles(unit_cycles), .iout_meas(iout_meas),
		.vout_low_pin(vout_low_pin), .on_pin(on_pin),
		.other_fault(other_fault), .clear_faults(clear_faults),
		.out_enable(out_enable), .oc_limit(oc_limit),
		.host_notify(host_notify), .status(status));
	// ====================================================================
	// helpers
	task automatic close_out();
		$display("mismatches %0d, checks %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ok(input logic c);
		chk({15'h0000, c}, 16'h0001);
	endtask
	function automatic logic sig(input int w);
		case (w)
			0: return out_enable;
			1: return status.limiting;
			default: return status.latched;
		endcase
	endfunction
	// bounded wait; n is the number of edges it took
	task automatic await(input int w, input logic want, output int n);
		for (n = 1; n < 3000; n++) begin
			@(posedge clk);
			#1;
			if (sig(w) === want)
				return;
		end
		n_mismatch++;
		close_out();
	endtask
	task automatic rises(input int cyc, output int r);
		logic prev;
		prev = out_enable;
		r = 0;
		repeat (cyc) begin
			@(posedge clk);
			#1;
			if (out_enable && !prev)
				r++;
			prev = out_enable;
		end
	endtask
	// clear faults, reprogram while off, then turn on again
	task automatic fresh(input logic [7:0] resp);
		int n;
		@(posedge clk);
		on_pin <= 1'b0;
		clear_faults <= 1'b1;
		iout_meas <= 16'h0004;
		other_fault <= 1'b0;
		vout_low_pin <= 1'b0;
		repeat (4) @(posedge clk);
		clear_faults <= 1'b0;
		host.setup(16'h0010, resp);
		#1;
		ok(!host_notify && !status.oc_fault);
		@(posedge clk);
		on_pin <= 1'b1;
		await(0, 1'b1, n);
		@(posedge clk);
		iout_meas <= 16'h0020;
	endtask
	// ====================================================================
	// scenarios
	task automatic s_regs();
		logic [15:0] d;
		host.rd(8'h47, d);
		chk(d, 16'h0000);
		host.wr(8'h46, 16'h1234);
		host.wr(8'h55, 16'hbeef);
		host.rd(8'h46, d);
		chk(d, 16'h1234);
		chk(oc_limit, 16'h1234);
		host.wr(8'h47, 16'habcd);
		host.rd(8'h47, d);
		chk(d, 16'h00cd);
		host.rd(8'h55, d);
		chk(d, 16'h0000);
	endtask
	task automatic s_brick();
		int n;
		fresh(8'h00);
		await(1, 1'b1, n);
		ok(host_notify && status.oc_fault);
		repeat (300) @(posedge clk);
		#1;
		ok(out_enable && status.limiting);
		// frozen: neither the off command nor the lower current may act
		@(posedge clk);
		ce <= 1'b0;
		on_pin <= 1'b0;
		iout_meas <= 16'h0004;
		repeat (10) @(posedge clk);
		#1;
		ok(out_enable && status.limiting);
		@(posedge clk);
		ce <= 1'b1;
		on_pin <= 1'b1;
		iout_meas <= 16'h0020;
	endtask
	task automatic s_cond();
		int n;
		fresh(8'h47);
		await(1, 1'b1, n);
		repeat (300) @(posedge clk);
		#1;
		ok(out_enable);
		@(posedge clk);
		vout_low_pin <= 1'b1;
		await(0, 1'b0, n);
		ok(n <= 4);
		repeat (20) @(posedge clk);
		#1;
		ok(status.latched && !out_enable);
	endtask
	task automatic s_delay();
		int n;
		@(posedge clk);
		unit_cycles <= 16'h0003;
		fresh(8'h82);
		await(1, 1'b1, n);
		await(0, 1'b0, n);
		ok(n >= 12 && n <= 14);
		repeat (20) @(posedge clk);
		#1;
		ok(status.latched && !out_enable);
		@(posedge clk);
		unit_cycles <= 16'(UNIT);
	endtask
	task automatic s_retry3();
		int n;
		int r;
		fresh(8'h99);
		await(0, 1'b0, n);
		await(0, 1'b1, n);
		ok(n >= 4 && n <= 7);
		rises(400, r);
		ok(r == 2);
		ok(status.latched && status.attempts === 3'h3);
	endtask
	task automatic s_success();
		int n;
		fresh(8'h99);
		await(0, 1'b0, n);
		@(posedge clk);
		iout_meas <= 16'h0004;
		await(0, 1'b1, n);
		repeat (30) @(posedge clk);
		#1;
		ok(out_enable && status.attempts === 3'h0);
	endtask
	task automatic s_endless();
		int n;
		int r;
		fresh(8'hf8);
		rises(300, r);
		ok(r > 7 && !status.latched);
		@(posedge clk);
		other_fault <= 1'b1;
		await(0, 1'b0, n);
		repeat (40) @(posedge clk);
		#1;
		ok(!out_enable && n <= 3);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		s_regs();
		s_brick();
		s_cond();
		s_delay();
		s_retry3();
		s_success();
		s_endless();
		close_out();
	end
endmodule
`default_nettype wire
